// ### src/mmsd_pkg.sv
// constants and helpers for the main memory select decoder
package mmsd_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL = 8'h44;
	localparam logic [7:0] IDX_HOLE_BOTTOM = 8'h45;
	localparam logic [7:0] IDX_HOLE_TOP = 8'h46;
	localparam logic [7:0] IDX_REGION_CFG = 8'h50;
	localparam logic [7:0] IDX_STATUS = 8'h51;
	localparam int IDX_SHIFT = 2;

	// reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_HOLE_BOTTOM = 8'h10;
	localparam logic [7:0] RST_HOLE_TOP = 8'h0f;
	localparam logic [7:0] RST_REGION_CFG = 8'h00;

	// control fields
	localparam int CTL_LOW_RD = 0;
	localparam int CTL_LOW_WR = 1;
	localparam int CTL_BIOS_RD = 2;
	localparam int CTL_BIOS_WR = 3;
	localparam int CTL_MASTER = 4;
	localparam logic [7:0] CTL_RW_MASK = 8'h1f;
	localparam int CFG_EXT_EN = 0;
	localparam logic [7:0] CFG_RW_MASK = 8'h01;

	// address map pieces, in 64 KByte blocks of address bits 23:16
	localparam logic [7:0] BLK_LOW_END = 8'h08;
	localparam logic [7:0] BLK_MID_END = 8'h0a;
	localparam logic [7:0] BLK_BIOS = 8'h0f;
	localparam logic [7:0] BLK_EXT_START = 8'h10;

	// pci memory commands on c/be_n in the address phase
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
	localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
	localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;

	function automatic logic mmsd_is_rd(input logic [3:0] cmd);
		return (cmd == CMD_MEM_RD) || (cmd == CMD_MEM_RD_MULT) || (cmd == CMD_MEM_RD_LINE);
	endfunction : mmsd_is_rd

	function automatic logic mmsd_is_wr(input logic [3:0] cmd);
		return (cmd == CMD_MEM_WR) || (cmd == CMD_MEM_WR_INV);
	endfunction : mmsd_is_wr
endpackage : mmsd_pkg

// ### src/mmsd_hole_cmp.sv
// hole comparator for the main memory select
module mmsd_hole_cmp
	import mmsd_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic [7:0] holeBottom,
	input wire logic [7:0] holeTop,
	output logic inHole
);
	logic below16M;
	logic holeOn;
	always_comb begin
		below16M = (addr[31:24] == 8'h00);
		holeOn = (holeTop >= holeBottom);
		// bottom block starts the hole, top block is included whole
		inHole = below16M && holeOn && (addr[23:16] >= holeBottom) && (addr[23:16] <= holeTop);
	end
endmodule : mmsd_hole_cmp

// ### src/mmsd_seg_decode.sv
// segment decode of the main memory region
module mmsd_seg_decode
	import mmsd_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic isRd,
	input wire logic isWr,
	input wire logic [7:0] control,
	input wire logic extEnable,
	output logic regionHit
);
	logic below16M;
	logic [7:0] blk;
	logic lowSeg;
	logic midSeg;
	logic biosSeg;
	logic extSeg;
	always_comb begin
		below16M = (addr[31:24] == 8'h00);
		blk = addr[23:16];
		lowSeg = below16M && (blk < BLK_LOW_END);
		midSeg = below16M && (blk >= BLK_LOW_END) && (blk < BLK_MID_END);
		biosSeg = below16M && (blk == BLK_BIOS);
		extSeg = below16M && (blk >= BLK_EXT_START);
		regionHit = 1'b0;
		if (lowSeg) begin
			regionHit = isRd || isWr;
		end else if (midSeg) begin
			// both enables clear leaves the segment unreachable
			regionHit = (isRd && control[CTL_LOW_RD]) || (isWr && control[CTL_LOW_WR]);
		end else if (biosSeg) begin
			regionHit = (isRd && control[CTL_BIOS_RD]) || (isWr && control[CTL_BIOS_WR]);
		end else if (extSeg) begin
			regionHit = extEnable && (isRd || isWr);
		end
	end
endmodule : mmsd_seg_decode

// ### src/mmsd_top.sv
// main memory select decoder with apb register access
module mmsd_top
	import mmsd_pkg::*;
#(
	parameter int APB_AW = 12
)
(
	input wire logic clk_sys,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// pci bus observation
	input wire logic frameN,
	input wire logic irdyN,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbeN,
	// positive decode requests from neighbouring decoders
	input wire logic isaClkDivBit6,
	input wire logic utilCsABit6,
	// outputs
	output logic main_memory_select_n,
	output logic isaClkPosDecodeEn,
	output logic utilCsAPosDecodeEn
);
	// refused at elaboration, the index decode needs bits 9:2
	if (APB_AW < 10 || APB_AW > 32) begin : g_bad_aw
		$error("mmsd_top: APB_AW must lie in 10..32");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HIT = 2'b01,
		ST_MISS = 2'b10
	} mmsd_state_t;

	// register file state
	logic [7:0] control;
	logic [7:0] holeBottom;
	logic [7:0] holeTop;
	logic [7:0] regionCfg;
	logic [7:0] next_control;
	logic [7:0] next_holeBottom;
	logic [7:0] next_holeTop;
	logic [7:0] next_regionCfg;

	// apb answer state
	logic next_pready;
	logic [31:0] next_prdata;
	logic next_pslverr;

	// transaction state
	mmsd_state_t state;
	mmsd_state_t next_state;
	logic next_selN;
	logic lastHit;
	logic lastHole;
	logic next_lastHit;
	logic next_lastHole;
	logic [7:0] selCount;
	logic [7:0] next_selCount;
	logic next_isaPos;
	logic next_utilPos;

	// decode wires
	logic isRd;
	logic isWr;
	logic regionHit;
	logic inHole;
	logic masterEn;
	logic decodeHit;
	logic addrPhase;
	logic busIdle;

	// register index seen on the bus
	logic [7:0] regIdx;
	logic idxMapped;
	logic wordAligned;
	logic upperZero;
	logic accessDone;
	logic setupPhase;
	logic [15:0] statusWord;

	always_comb begin
		isRd = mmsd_is_rd(cbeN);
		isWr = mmsd_is_wr(cbeN);
	end

	mmsd_seg_decode u_seg (
		.addr(ad),
		.isRd(isRd),
		.isWr(isWr),
		.control(control),
		.extEnable(regionCfg[CFG_EXT_EN]),
		.regionHit(regionHit)
	);

	mmsd_hole_cmp u_hole (
		.addr(ad),
		.holeBottom(holeBottom),
		.holeTop(holeTop),
		.inHole(inHole)
	);

	always_comb begin
		masterEn = control[CTL_MASTER];
		// master enable gates everything, the hole overrides the region
		decodeHit = masterEn && regionHit && !inHole;
		busIdle = frameN && irdyN;
		// only in idle is a falling frame an address phase
		addrPhase = (state == ST_IDLE) && !frameN;
	end

	// apb address decode
	always_comb begin
		regIdx = paddr[IDX_SHIFT +: 8];
		wordAligned = (paddr[IDX_SHIFT-1:0] == '0);
		upperZero = 1'b1;
		if (APB_AW > IDX_SHIFT + 8) begin
			upperZero = ((paddr >> (IDX_SHIFT + 8)) == '0);
		end
		idxMapped = (regIdx == IDX_CONTROL) || (regIdx == IDX_HOLE_BOTTOM) || (regIdx == IDX_HOLE_TOP) ||
			(regIdx == IDX_REGION_CFG) || (regIdx == IDX_STATUS);
		idxMapped = idxMapped && wordAligned && upperZero;
		setupPhase = psel && !penable;
		accessDone = psel && penable && pready;
		statusWord = {selCount, 5'h00, lastHole, lastHit, !main_memory_select_n};
	end

	// register writes land on the completing access edge only
	always_comb begin
		next_control = control;
		next_holeBottom = holeBottom;
		next_holeTop = holeTop;
		next_regionCfg = regionCfg;
		if (accessDone && pwrite && idxMapped && pstrb[0]) begin
			case (regIdx)
				IDX_CONTROL: begin
					next_control = pwdata[7:0] & CTL_RW_MASK;
				end
				IDX_HOLE_BOTTOM: begin
					next_holeBottom = pwdata[7:0];
				end
				IDX_HOLE_TOP: begin
					next_holeTop = pwdata[7:0];
				end
				IDX_REGION_CFG: begin
					next_regionCfg = pwdata[7:0] & CFG_RW_MASK;
				end
				default: begin
					next_control = control;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			control <= RST_CONTROL;
			holeBottom <= RST_HOLE_BOTTOM;
			holeTop <= RST_HOLE_TOP;
			regionCfg <= RST_REGION_CFG;
		end else begin
			control <= next_control;
			holeBottom <= next_holeBottom;
			holeTop <= next_holeTop;
			regionCfg <= next_regionCfg;
		end
	end

	// answer prepared in setup, so the access phase needs no wait state
	always_comb begin
		next_pready = 1'b0;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (setupPhase) begin
			next_pready = 1'b1;
			next_pslverr = !idxMapped;
			next_prdata = 32'h0000_0000;
			if (!pwrite && idxMapped) begin
				case (regIdx)
					IDX_CONTROL: begin
						next_prdata = {24'h00_0000, control};
					end
					IDX_HOLE_BOTTOM: begin
						next_prdata = {24'h00_0000, holeBottom};
					end
					IDX_HOLE_TOP: begin
						next_prdata = {24'h00_0000, holeTop};
					end
					IDX_REGION_CFG: begin
						next_prdata = {24'h00_0000, regionCfg};
					end
					IDX_STATUS: begin
						next_prdata = {16'h0000, statusWord};
					end
					default: begin
						next_prdata = 32'h0000_0000;
					end
				endcase
			end
		end else if (psel && penable && !pready) begin
			// held request whose setup was missed is answered one cycle late
			next_pready = 1'b1;
			next_pslverr = !idxMapped;
			next_prdata = prdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// transaction tracking; the decision is frozen at the address phase
	always_comb begin
		next_state = state;
		next_lastHit = lastHit;
		next_lastHole = lastHole;
		next_selCount = selCount;
		case (state)
			ST_IDLE: begin
				if (addrPhase) begin
					next_lastHit = decodeHit;
					next_lastHole = inHole;
					if (decodeHit) begin
						next_state = ST_HIT;
						next_selCount = selCount + 8'h01;
					end else begin
						next_state = ST_MISS;
					end
				end
			end
			ST_HIT: begin
				if (busIdle) begin
					next_state = ST_IDLE;
				end
			end
			ST_MISS: begin
				if (busIdle) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// later control writes never cut a running transaction short
		next_selN = (next_state != ST_HIT);
	end

	// with the master enable set those areas fall to subtractive decode
	always_comb begin
		next_isaPos = isaClkDivBit6 && !masterEn;
		next_utilPos = utilCsABit6 && !masterEn;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= ST_IDLE;
			main_memory_select_n <= 1'b1;
			lastHit <= 1'b0;
			lastHole <= 1'b0;
			selCount <= 8'h00;
			isaClkPosDecodeEn <= 1'b0;
			utilCsAPosDecodeEn <= 1'b0;
		end else begin
			state <= next_state;
			main_memory_select_n <= next_selN;
			lastHit <= next_lastHit;
			lastHole <= next_lastHole;
			selCount <= next_selCount;
			isaClkPosDecodeEn <= next_isaPos;
			utilCsAPosDecodeEn <= next_utilPos;
		end
	end
endmodule : mmsd_top

// ### dv/mmsd_checker_sva.sv
// checker for the main memory select decoder
module mmsd_checker #(
	parameter int APB_AW = 12
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic frameN,
	input wire logic irdyN,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbeN,
	input wire logic isaClkDivBit6,
	input wire logic utilCsABit6,
	input wire logic main_memory_select_n,
	input wire logic isaClkPosDecodeEn,
	input wire logic utilCsAPosDecodeEn
);
	logic busy;
	logic [7:0] ctl;
	logic [7:0] bot;
	logic [7:0] top;
	// shadow copies snooped from apb writes, so the checker needs no internal probes
	wire wrEn = psel && penable && pready && pwrite && pstrb[0];
	wire addrPh = !busy && !frameN;
	wire isRd = cbeN == 4'h6 || cbeN == 4'hc || cbeN == 4'he;
	wire isWr = cbeN == 4'h7 || cbeN == 4'hf;
	wire [7:0] blk = ad[23:16];
	wire up0 = ad[31:24] == 8'h00;
	wire selN = main_memory_select_n;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			busy <= 1'b0;
			ctl <= 8'h00;
			bot <= 8'h10;
			top <= 8'h0f;
		end else begin
			busy <= busy ? !(frameN && irdyN) : !frameN;
			if (wrEn && paddr == 'h110)
				ctl <= pwdata[7:0];
			if (wrEn && paddr == 'h114)
				bot <= pwdata[7:0];
			if (wrEn && paddr == 'h118)
				top <= pwdata[7:0];
		end
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	a_off_none: assert property (addrPh && !ctl[4] |=> selN)
		else $error("select while disabled");
	a_low_seg: assert property (addrPh && ctl[4] && up0 && blk < 8'h08 && (isRd || isWr) |=> !selN)
		else $error("low segment not selected");
	a_mid_gate: assert property (addrPh && up0 && blk[7:1] == 7'h04 && (isRd && !ctl[0] || isWr && !ctl[1]) |=> selN)
		else $error("mid segment select not gated");
	a_bios_gate: assert property (addrPh && up0 && blk == 8'h0f && (isRd && !ctl[2] || isWr && !ctl[3]) |=> selN)
		else $error("bios select not gated");
	a_hole_cut: assert property (addrPh && up0 && top >= bot && blk >= bot && blk <= top |=> selN)
		else $error("select inside hole");
	a_cmd_only: assert property (addrPh && !isRd && !isWr |=> selN)
		else $error("select on non memory command");
	a_sel_start: assert property ($fell(selN) |-> $past(addrPh))
		else $error("select without address phase");
	a_sel_hold: assert property (!selN && !(frameN && irdyN) |=> !selN)
		else $error("select dropped early");
	a_sel_end: assert property (!selN && frameN && irdyN |=> selN)
		else $error("select held past idle");
	a_pos_block: assert property (ctl[4] |=> !isaClkPosDecodeEn && !utilCsAPosDecodeEn)
		else $error("positive decode not ignored");
	a_pos_pass: assert property (!$past(reset) && !ctl[4] && isaClkDivBit6 && utilCsABit6
		|=> isaClkPosDecodeEn && utilCsAPosDecodeEn)
		else $error("positive decode lost");
	c_sel: cover property ($fell(selN));
	c_hole: cover property (addrPh && top >= bot && blk >= bot && blk <= top);
	c_pos: cover property (isaClkPosDecodeEn);
endmodule : mmsd_checker

bind mmsd_top mmsd_checker #(.APB_AW(APB_AW)) u_chk (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .pready, .frameN, .irdyN, .ad, .cbeN, .isaClkDivBit6, .utilCsABit6,
	.main_memory_select_n, .isaClkPosDecodeEn, .utilCsAPosDecodeEn);

// ### dv/mmsd_pci_master.sv
// pci master model issuing single data phase memory transfers
module mmsd_pci_master (
	input wire logic clk_sys,
	input wire logic main_memory_select_n,
	output logic frameN,
	output logic irdyN,
	output logic [31:0] ad,
	output logic [3:0] cbeN
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		frameN = 1'b1;
		irdyN = 1'b1;
		ad = 32'h0;
		cbeN = 4'hf;
	end
	// lines outside the address phase carry changing junk, never the last address
	task automatic xfer(input logic [31:0] a, input logic [3:0] c, input int waits, output logic hit);
		@(posedge clk_sys);
		frameN <= 1'b0;
		ad <= a;
		cbeN <= c;
		@(posedge clk_sys);
		ad <= ~a;
		cbeN <= 4'h0;
		repeat (waits) @(posedge clk_sys);
		frameN <= 1'b1;
		irdyN <= 1'b0;
		@(negedge clk_sys);
		hit = main_memory_select_n === 1'b0;
		@(posedge clk_sys);
		irdyN <= 1'b1;
		ad <= a ^ 32'h5a5a5a5a;
		cbeN <= ~c;
		@(posedge clk_sys);
	endtask : xfer
endmodule : mmsd_pci_master

// ### dv/tb_main_memory_select_decoder.sv
// testbench for the main memory select decoder
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_main_memory_select_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, reset, psel, penable, pwrite, isaB6, utilB6, pready, pslverr, selN, isaEn, utilEn;
	logic frameN, irdyN, hit, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, ad, rdat;
	logic [3:0] cbeN;
	logic [3:0] cmds [7] = '{4'h6, 4'h7, 4'hc, 4'he, 4'hf, 4'h2, 4'h3};
	logic [31:0] hAd [4] = '{32'h001fffff, 32'h00200000, 32'h0021ffff, 32'h00220000};
	logic [3:0] hEx = 4'b1001;
	int mismatches = 0;
	int total_checks = 0;
	int nx = 0;
	mmsd_top #(.APB_AW(12)) dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .frameN(frameN), .irdyN(irdyN), .ad(ad), .cbeN(cbeN), .isaClkDivBit6(isaB6),
		.utilCsABit6(utilB6), .main_memory_select_n(selN), .isaClkPosDecodeEn(isaEn),
		.utilCsAPosDecodeEn(utilEn));
	mmsd_pci_master pci (.clk_sys(clk_sys), .main_memory_select_n(selN), .frameN(frameN), .irdyN(irdyN),
		.ad(ad), .cbeN(cbeN));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			tally_and_finish();
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask : rchk
	// wait states rotate so prompt and slow masters both occur
	task automatic pchk(input logic [31:0] a, input logic [3:0] c, input logic e);
		pci.xfer(a, c, nx % 3, hit);
		nx++;
		`CHK(hit, e)
	endtask : pchk
	initial begin
		{reset, psel, penable, pwrite, isaB6, utilB6} = 6'b100000;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		rchk(12'h110, 32'h00);
		rchk(12'h114, 32'h10);
		rchk(12'h118, 32'h0f);
		apb(1'b0, 12'h120, 32'h0);
		`CHK({err, rdat}, 33'h100000000)
		apb(1'b1, 12'h110, 32'h0f);
		pchk(32'h0, 4'h6, 1'b0);
		pchk(32'h000f0000, 4'h7, 1'b0);
		apb(1'b1, 12'h110, 32'h10);
		pchk(32'h0007fffc, 4'h7, 1'b1);
		pchk(32'h00080000, 4'h6, 1'b0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h110, 32'h10 | (32'h1 << i));
			for (int j = 0; j < 4; j++)
				pchk(j < 2 ? 32'h0009fff0 : 32'h000f0000, j[0] ? 4'h7 : 4'h6, i == j);
		end
		apb(1'b1, 12'h110, 32'h1f);
		foreach (cmds[k])
			pchk(32'h00010000, cmds[k], k < 5);
		isaB6 <= 1'b1;
		utilB6 <= 1'b1;
		apb(1'b1, 12'h110, 32'h00);
		repeat (3) @(negedge clk_sys);
		`CHK({isaEn, utilEn}, 2'b11)
		apb(1'b1, 12'h110, 32'h10);
		repeat (3) @(negedge clk_sys);
		`CHK({isaEn, utilEn}, 2'b00)
		apb(1'b1, 12'h140, 32'h1);
		apb(1'b1, 12'h114, 32'h20);
		apb(1'b1, 12'h118, 32'h21);
		foreach (hAd[k])
			pchk(hAd[k], 4'h6, hEx[k]);
		apb(1'b1, 12'h118, 32'h1f);
		pchk(32'h00200000, 4'h6, 1'b1);
		apb(1'b1, 12'h118, 32'h20);
		pchk(32'h00200000, 4'h7, 1'b0);
		rchk(12'h140, 32'h01);
		// thirteen selected transfers so far, last one fell in the hole
		rchk(12'h144, 32'h0d04);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rchk(12'h110, 32'h00);
		rchk(12'h114, 32'h10);
		rchk(12'h118, 32'h0f);
		rchk(12'h144, 32'h00);
		tally_and_finish();
	end
endmodule : tb_main_memory_select_decoder
